//--- pkg/rtc_pkg.sv
package rtc_pkg;
    localparam int          NUM_CLOCK_REGS    = 14;
    localparam int          RAM_BYTES         = 242;
    localparam int          TIME_BYTES        = 10;
    localparam logic [7:0]  ADDR_CTRL_A       = 8'h0A;
    localparam logic [7:0]  ADDR_CTRL_B       = 8'h0B;
    localparam logic [7:0]  ADDR_FLAGS        = 8'h0C;
    localparam logic [7:0]  ADDR_VALID        = 8'h0D;
    localparam logic [7:0]  ADDR_RAM_BASE     = 8'h0E;
    localparam logic [3:0]  ADDR_SEC_MATCH    = 4'h1;
    localparam logic [3:0]  ADDR_MIN_MATCH    = 4'h3;
    localparam logic [3:0]  ADDR_HR_MATCH     = 4'h5;
    // Buffer addresses of the seven running bytes
    localparam logic [6:0][3:0] TIME_ADDR     = {4'h9, 4'h8, 4'h7, 4'h6, 4'h4, 4'h2, 4'h0};
    localparam int          T_SEC             = 0;
    localparam int          T_MIN             = 1;
    localparam int          T_HR              = 2;
    localparam int          T_WDAY            = 3;
    localparam int          T_MDAY            = 4;
    localparam int          T_MON             = 5;
    localparam int          T_YR              = 6;
    localparam int          A_PEND_BIT        = 7;
    localparam int          A_OSC_LSB         = 4;
    localparam int          B_FREEZE_BIT      = 7;
    localparam int          B_PER_EN_BIT      = 6;
    localparam int          B_ALM_EN_BIT      = 5;
    localparam int          B_UPD_EN_BIT      = 4;
    localparam int          B_BIN_BIT         = 2;
    localparam int          B_H24_BIT         = 1;
    localparam logic [7:0]  VALID_READ        = 8'h80;
    localparam logic [6:0]  RST_CTRL_A        = 7'h00;
    localparam logic [7:0]  RST_CTRL_B        = 8'h00;
    localparam logic [1:0]  OSC_RUN_PAT       = 2'b01;
    localparam logic [1:0]  OSC_HOLD_PAT      = 2'b11;
    localparam logic [2:0]  OSC_START         = 3'b010;
    localparam int          DIV_BITS          = 15;
    localparam logic [14:0] DIV_HALF          = 15'h4000;
    localparam int          PRE_UPDATE_WINDOW = 8;
    localparam logic [7:0]  SEC_MAX           = 8'h3B;
    localparam logic [7:0]  HR24_MAX          = 8'h17;
    localparam logic [7:0]  HR12_TOP          = 8'h0C;
    localparam logic [7:0]  HR12_PRE          = 8'h0B;
    localparam logic [7:0]  WDAY_MAX          = 8'h07;
    localparam logic [7:0]  MON_MAX           = 8'h0C;
    localparam logic [7:0]  YR_MAX            = 8'h63;

    typedef struct packed {
        logic       addr_strobe;
        logic       data_strobe;
        logic       rd_wr_n;
        logic       chip_sel_n;
        logic       ext_mem_select;
        logic [7:0] ad;
    } rtc_bus_in_t;

    typedef struct packed {
        rtc_bus_in_t                  bus_s0;
        rtc_bus_in_t                  bus_s1;
        logic [1:0]                   osc_s;
        logic [1:0]                   sup_s;
        logic                         as_d;
        logic                         ds_d;
        logic                         osc_d;
        logic [7:0]                   addr;
        logic                         addr_ext;
        logic [7:0]                   dout;
        logic                         tick;
        logic [DIV_BITS-1:0]          div;
        logic                         update_pending;
        logic [6:0]                   ctrl_a;
        logic [7:0]                   ctrl_b;
        logic                         irq_summary_flag;
        logic                         periodic_flag;
        logic                         alarm_flag;
        logic                         update_done_flag;
        logic                         loaded;
        logic [TIME_BYTES-1:0][7:0]   ubuf;
        logic [6:0][7:0]              loc;
        logic [RAM_BYTES-1:0][7:0]    ram;
    } rtc_state_t;

    localparam rtc_state_t RTC_RST = '0;
endpackage

//--- rtl/rtc_core.sv
`timescale 1ns/1ps
// Contract
// - 14 clock/control bytes and 242 storage bytes share one byte map.
// - Time and calendar advance in one update cycle each second.
// - Freeze holds the host copy; the running copy keeps advancing.
// - Pending bit rises before each update while freeze is clear; cleared and done flag set after.
// - First update with freeze clear after new writes takes the seven time bytes in current formats.
// - Seconds, minutes and their match bytes count 0 to 59.
// - Hours count 1-12 with PM in bit 7, or 0-23.
// - Weekday 1-7, month day 1-31, month 1-12, year 0-99.
// - Low-voltage tick output runs with oscillator; 5V one with valid supply.
// - Each event sets its flag always; request only when enabled.
// - Any request sets the summary flag and pulls the interrupt pin low.
// - Reading the flag register clears all flags and releases the pin.
// - Four-bit rate code picks periodic event period, zero means none.
// - Each update compares time with match bytes and flags an alarm.
// - Match byte with both top bits set is excluded from compare.
// - Alarm detection and interrupt keep working on the backup cell.
// - Update request needs update enable set and freeze clear.
// - Oscillator code 010 runs, 11X holds divider; first update 500 ms later.
// - Hour format bit 1 is 24-hour; number format bit 1 is binary.
// - Setting freeze clears the update interrupt enable.
module rtc_core
    import rtc_pkg::*;
#(
    parameter bit LOW_VOLT  = 1'b1,
    parameter int PRE_TICKS = PRE_UPDATE_WINDOW
) (
    input  logic        clk_sys,
    input  logic        resetn,
    input  rtc_bus_in_t bus_in,
    input  logic        osc_in,
    input  logic        supply_ok,
    output logic [7:0]  ad_o,
    output logic        ad_oe,
    output logic        int_n_o,
    output logic        int_n_oe,
    output logic        tick_out
);

    localparam logic [DIV_BITS-1:0] PRE_START = DIV_BITS'(2 ** DIV_BITS - PRE_TICKS);

    rtc_state_t s;
    rtc_state_t n;

    logic       as_fall;
    logic       ds_fall;
    logic       acc_ok;
    logic       wr;
    logic       rd_end;
    logic       clr;
    logic       osc_tick;
    logic       run;
    logic       osc_on;
    logic       upd;
    logic       ev_p;
    logic       ev_a;
    logic       irq_req;
    logic [3:0] rate_select;
    logic [2:0] osc_ctrl;
    logic       transfer_freeze;
    logic       number_format_sel;
    logic       hour_format_sel;
    logic       periodic_irq_en;
    logic       alarm_irq_en;
    logic       update_irq_en;

    function automatic logic [7:0] rtc_inc(input logic [7:0] v, input logic bin);
        if (bin || v[3:0] != 4'h9) begin
            return v + 8'h01;
        end
        return {v[7:4] + 4'h1, 4'h0};
    endfunction

    function automatic logic [7:0] rtc_val(input logic [7:0] v, input logic bin);
        if (bin) begin
            return v;
        end
        return ({4'h0, v[7:4]} * 8'h0A) + {4'h0, v[3:0]};
    endfunction

    function automatic logic [7:0] rtc_dim(input logic [7:0] mon, input logic [7:0] yr);
        case (mon)
            8'h02:   return (yr[1:0] == 2'b00) ? 8'h1D : 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: return 8'h1E;
            default: return 8'h1F;
        endcase
    endfunction

    // Out-of-range bytes fall back to the wrap value instead of running on
    function automatic logic [6:0][7:0] rtc_step(input logic [6:0][7:0] t, input logic bin,
                                                 input logic h24);
        logic [6:0][7:0] r;
        logic            c;
        logic [7:0]      x;
        r = t;
        c = 1'b0;
        x = rtc_inc({1'b0, t[T_HR][6:0]}, bin);
        if (rtc_val(t[T_SEC], bin) >= SEC_MAX) begin
            r[T_SEC] = 8'h00;
            c        = 1'b1;
        end else begin
            r[T_SEC] = rtc_inc(t[T_SEC], bin);
        end
        if (c) begin
            c = 1'b0;
            if (rtc_val(t[T_MIN], bin) >= SEC_MAX) begin
                r[T_MIN] = 8'h00;
                c        = 1'b1;
            end else begin
                r[T_MIN] = rtc_inc(t[T_MIN], bin);
            end
        end
        if (c) begin
            c = 1'b0;
            if (h24) begin
                if (rtc_val(t[T_HR], bin) >= HR24_MAX) begin
                    r[T_HR] = 8'h00;
                    c       = 1'b1;
                end else begin
                    r[T_HR] = rtc_inc(t[T_HR], bin);
                end
            end else if (rtc_val({1'b0, t[T_HR][6:0]}, bin) >= HR12_TOP) begin
                r[T_HR] = {t[T_HR][7], 7'h01};
            end else if (rtc_val({1'b0, t[T_HR][6:0]}, bin) == HR12_PRE) begin
                r[T_HR] = {~t[T_HR][7], bin ? HR12_TOP[6:0] : 7'h12};
                c       = t[T_HR][7];
            end else begin
                r[T_HR] = {t[T_HR][7], x[6:0]};
            end
        end
        if (c) begin
            c = 1'b0;
            r[T_WDAY] = (rtc_val(t[T_WDAY], bin) >= WDAY_MAX) ? 8'h01 : rtc_inc(t[T_WDAY], bin);
            if (rtc_val(t[T_MDAY], bin) >= rtc_dim(rtc_val(t[T_MON], bin), rtc_val(t[T_YR], bin))) begin
                r[T_MDAY] = 8'h01;
                c         = 1'b1;
            end else begin
                r[T_MDAY] = rtc_inc(t[T_MDAY], bin);
            end
        end
        if (c) begin
            c = 1'b0;
            if (rtc_val(t[T_MON], bin) >= MON_MAX) begin
                r[T_MON] = 8'h01;
                c        = 1'b1;
            end else begin
                r[T_MON] = rtc_inc(t[T_MON], bin);
            end
        end
        if (c) begin
            r[T_YR] = (rtc_val(t[T_YR], bin) >= YR_MAX) ? 8'h00 : rtc_inc(t[T_YR], bin);
        end
        return r;
    endfunction

    function automatic logic rtc_hit(input logic [7:0] m, input logic [7:0] v);
        return (m[7:6] == 2'b11) || (m == v);
    endfunction

    assign rate_select       = s.ctrl_a[3:0];
    assign osc_ctrl          = s.ctrl_a[A_OSC_LSB+2:A_OSC_LSB];
    assign transfer_freeze   = s.ctrl_b[B_FREEZE_BIT];
    assign number_format_sel = s.ctrl_b[B_BIN_BIT];
    assign hour_format_sel   = s.ctrl_b[B_H24_BIT];
    assign periodic_irq_en   = s.ctrl_b[B_PER_EN_BIT];
    assign alarm_irq_en      = s.ctrl_b[B_ALM_EN_BIT];
    assign update_irq_en     = s.ctrl_b[B_UPD_EN_BIT];

    // Only the second sync stage and its delayed copy feed edge logic
    assign as_fall  = s.as_d & ~s.bus_s1.addr_strobe;
    assign ds_fall  = s.ds_d & ~s.bus_s1.data_strobe;
    assign acc_ok   = ~s.bus_s1.chip_sel_n & ~s.addr_ext & s.sup_s[1];
    assign wr       = ds_fall & ~s.bus_s1.rd_wr_n & acc_ok;
    assign rd_end   = ds_fall & s.bus_s1.rd_wr_n & acc_ok;
    assign clr      = rd_end & (s.addr == ADDR_FLAGS);
    assign osc_tick = s.osc_s[1] & ~s.osc_d;
    assign run      = osc_ctrl[2:1] == OSC_RUN_PAT;
    assign osc_on   = run | (osc_ctrl[2:1] == OSC_HOLD_PAT);
    assign upd      = osc_tick & run & (s.div == '1);
    assign irq_req  = (s.periodic_flag & periodic_irq_en) | (s.alarm_flag & alarm_irq_en)
                    | (s.update_done_flag & update_irq_en & ~transfer_freeze);

    assign ad_o     = s.dout;
    assign ad_oe    = s.bus_s1.data_strobe & s.bus_s1.rd_wr_n & acc_ok;
    assign int_n_o  = 1'b0;
    assign int_n_oe = s.irq_summary_flag;
    assign tick_out = s.tick;

    always_comb begin
        logic [6:0][7:0]     base;
        logic [6:0][7:0]     stepped;
        logic [DIV_BITS-1:0] nd;
        logic [DIV_BITS-1:0] mask;
        logic [3:0]          k;
        logic                from_buf;
        base     = s.loc;
        stepped  = s.loc;
        nd       = s.div + 15'h0001;
        k        = (rate_select >= 4'h3) ? rate_select - 4'h1 : rate_select + 4'h6;
        mask     = (15'h0001 << k) - 15'h0001;
        from_buf = s.loaded & ~transfer_freeze;
        n        = s;
        n.bus_s0 = bus_in;
        n.bus_s1 = s.bus_s0;
        n.osc_s  = {s.osc_s[0], osc_in};
        n.sup_s  = {s.sup_s[0], supply_ok};
        n.as_d   = s.bus_s1.addr_strobe;
        n.ds_d   = s.bus_s1.data_strobe;
        n.osc_d  = s.osc_s[1];
        if (as_fall) begin
            n.addr     = s.bus_s1.ad;
            n.addr_ext = s.bus_s1.ext_mem_select;
        end
        if (!run) begin
            n.div = '0;
        end else if (osc_tick) begin
            n.div = nd;
        end
        for (int i = 0; i < 7; i++) begin
            if (from_buf) begin
                base[i] = s.ubuf[TIME_ADDR[i]];
            end
        end
        stepped = rtc_step(base, number_format_sel, hour_format_sel);
        ev_p = osc_tick & run & (rate_select != 4'h0) & ((nd & mask) == '0);
        // Compare runs on every update, no supply term involved
        ev_a = upd & rtc_hit(s.ubuf[ADDR_SEC_MATCH], stepped[T_SEC])
                   & rtc_hit(s.ubuf[ADDR_MIN_MATCH], stepped[T_MIN])
                   & rtc_hit(s.ubuf[ADDR_HR_MATCH], stepped[T_HR]);
        if (upd) begin
            n.loc = stepped;
            if (from_buf) begin
                n.loaded = 1'b0;
            end
            if (!transfer_freeze) begin
                for (int i = 0; i < 7; i++) begin
                    n.ubuf[TIME_ADDR[i]] = stepped[i];
                end
            end
        end
        // Set wins over a read-clear in the same cycle
        n.periodic_flag    = (s.periodic_flag & ~clr) | ev_p;
        n.alarm_flag       = (s.alarm_flag & ~clr) | ev_a;
        n.update_done_flag = (s.update_done_flag & ~clr) | upd;
        if (wr) begin
            if (s.addr < 8'(TIME_BYTES)) begin
                n.ubuf[s.addr[3:0]] = s.bus_s1.ad;
                n.loaded            = 1'b1;
            end else if (s.addr == ADDR_CTRL_A) begin
                n.ctrl_a = s.bus_s1.ad[6:0];
                if (s.bus_s1.ad[A_OSC_LSB+2:A_OSC_LSB] == OSC_START && !run) begin
                    n.div = DIV_HALF;
                end
            end else if (s.addr == ADDR_CTRL_B) begin
                n.ctrl_b = s.bus_s1.ad;
            end else if (s.addr >= ADDR_RAM_BASE) begin
                n.ram[s.addr - ADDR_RAM_BASE] = s.bus_s1.ad;
            end
        end
        if (n.ctrl_b[B_FREEZE_BIT]) begin
            n.ctrl_b[B_UPD_EN_BIT] = 1'b0;
        end
        n.irq_summary_flag = (s.irq_summary_flag & ~clr)
            | (n.periodic_flag & n.ctrl_b[B_PER_EN_BIT])
            | (n.alarm_flag & n.ctrl_b[B_ALM_EN_BIT])
            | (n.update_done_flag & n.ctrl_b[B_UPD_EN_BIT] & ~n.ctrl_b[B_FREEZE_BIT]);
        // Pending drops on the same edge that ends the update
        n.update_pending = (n.ctrl_a[A_OSC_LSB+2:A_OSC_LSB+1] == OSC_RUN_PAT)
                         & ~n.ctrl_b[B_FREEZE_BIT] & (n.div >= PRE_START);
        if (s.addr < 8'(TIME_BYTES)) begin
            n.dout = s.ubuf[s.addr[3:0]];
        end else if (s.addr == ADDR_CTRL_A) begin
            n.dout = {s.update_pending, s.ctrl_a};
        end else if (s.addr == ADDR_CTRL_B) begin
            n.dout = s.ctrl_b;
        end else if (s.addr == ADDR_FLAGS) begin
            n.dout = {s.irq_summary_flag, s.periodic_flag, s.alarm_flag, s.update_done_flag, 4'h0};
        end else if (s.addr == ADDR_VALID) begin
            n.dout = VALID_READ;
        end else begin
            n.dout = s.ram[s.addr - ADDR_RAM_BASE];
        end
        n.tick = s.osc_s[1] & (LOW_VOLT ? osc_on : s.sup_s[1]);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s <= RTC_RST;
        end else begin
            s <= n;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence s_upd_done;
        s.update_done_flag && !s.update_pending;
    endsequence

    sequence s_all_clear;
        !s.periodic_flag && !s.alarm_flag && !s.update_done_flag && !int_n_oe;
    endsequence

    a_update_ends: assert property (upd |=> s_upd_done)
        else $error("update end not flagged");
    a_pend_leads: assert property (upd |-> s.update_pending || transfer_freeze)
        else $error("update without pending bit");
    a_read_clears: assert property (clr && !ev_p && !ev_a && !upd |=> s_all_clear)
        else $error("flag read did not clear");
    a_int_drive: assert property (irq_req |-> int_n_oe && !int_n_o)
        else $error("request not driven on pin");
    a_freeze_buf: assert property (upd && transfer_freeze && !wr |=> $stable(s.ubuf[0]))
        else $error("frozen buffer changed");
    a_uie_off: assert property (transfer_freeze |-> !update_irq_en)
        else $error("update enable left on in freeze");
    a_sec_range: assert property (upd && !wr |=> rtc_val(s.loc[T_SEC], number_format_sel) <= SEC_MAX)
        else $error("seconds out of range");
    a_alarm_flag: assert property (ev_a |=> s.alarm_flag)
        else $error("alarm flag not set");
    a_rate_none: assert property (ev_p |-> run && rate_select != 4'h0)
        else $error("periodic event while disabled");
    a_tick_gate: assert property (LOW_VOLT && !osc_on |=> !tick_out)
        else $error("tick output with oscillator off");
    a_first_half: assert property (wr && s.addr == ADDR_CTRL_A && !run
                                   && s.bus_s1.ad[6:4] == OSC_START |=> s.div == DIV_HALF)
        else $error("start did not preset divider");
    a_set_wins: assert property (ev_p |=> s.periodic_flag)
        else $error("periodic flag lost");
    a_upd_irq: assert property (upd && update_irq_en && !transfer_freeze && !wr |=> int_n_oe)
        else $error("update request not raised");
    a_alarm_irq: assert property (ev_a && alarm_irq_en && !wr |=> int_n_oe)
        else $error("alarm request not raised");
    a_pend_freeze: assert property (transfer_freeze && !wr |=> !s.update_pending)
        else $error("pending bit set during freeze");
endmodule

//--- verif/rtc_host_model.sv
`timescale 1ns/1ps
module rtc_host_model
    import rtc_pkg::*;
(
    input  logic        clk_sys,
    input  logic [7:0]  ad_o,
    input  logic        ad_oe,
    output rtc_bus_in_t bus_out
);
    logic       as_q   = 1'b0;
    logic       ds_q   = 1'b0;
    logic       rw_q   = 1'b1;
    logic       cs_n   = 1'b1;
    logic       ext    = 1'b0;
    logic       drv_en = 1'b0;
    logic [7:0] drv_ad = 8'h00;
    logic [7:0] last   = 8'h00;

    // Released bus shows a changing pattern, never the last byte
    assign bus_out = '{addr_strobe: as_q, data_strobe: ds_q, rd_wr_n: rw_q, chip_sel_n: cs_n,
                       ext_mem_select: ext, ad: ad_oe ? ad_o : (drv_en ? drv_ad : ~last)};

    always_ff @(posedge clk_sys) begin
        last <= bus_out.ad;
    end

    // Each phase held 3 clk or more so the pin synchronisers see it
    task automatic cycle(input logic [7:0] addr, input logic wr, input logic [7:0] wdata,
                         output logic [7:0] rdata);
        @(posedge clk_sys);
        as_q   <= 1'b1;
        drv_en <= 1'b1;
        drv_ad <= addr;
        repeat (3) @(posedge clk_sys);
        as_q   <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rw_q   <= ~wr;
        cs_n   <= 1'b0;
        ds_q   <= 1'b1;
        drv_en <= wr;
        drv_ad <= wdata;
        repeat (4) @(posedge clk_sys);
        rdata = bus_out.ad;
        ds_q   <= 1'b0;
        repeat (3) @(posedge clk_sys);
        cs_n   <= 1'b1;
        drv_en <= 1'b0;
        rw_q   <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        cycle(addr, 1'b1, data, unused);
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        cycle(addr, 1'b0, 8'h00, data);
    endtask
endmodule

//--- verif/rtc_timekeeping_interrupts_tb.sv
`timescale 1ns/1ps
module rtc_timekeeping_interrupts_tb
    import rtc_pkg::*;
;
    logic        clk_sys    = 1'b0;
    logic        resetn     = 1'b0;
    logic        osc_in     = 1'b0;
    logic        supply_ok  = 1'b1;
    rtc_bus_in_t bus_in;
    logic [7:0]  ad_o;
    logic        ad_oe;
    logic        int_n_o;
    logic        int_n_oe;
    logic        tick_out;
    logic        int_pin;
    logic [7:0]  rdata;
    int          fail_count = 0;
    int          n_compared = 0;
    int          cycles     = 0;
    // 23:59:59 Saturday, Feb 28 of a leap year; hour match is don't care
    logic [7:0]  prog [10]  = '{8'h3B, 8'h00, 8'h3B, 8'h00, 8'h17, 8'hC0, 8'h07, 8'h1C, 8'h02, 8'h04};
    logic [7:0]  expv [10]  = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h01, 8'h1D, 8'h02, 8'h04};

    always #5 clk_sys = ~clk_sys;

    // Fastest time base keeps the first update inside the run
    always @(posedge clk_sys) begin
        osc_in <= ~osc_in;
    end

    // Open-drain pin with pull-up
    assign int_pin = int_n_oe ? int_n_o : 1'b1;

    rtc_core #(.LOW_VOLT(1'b1), .PRE_TICKS(64)) dut (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .bus_in    (bus_in),
        .osc_in    (osc_in),
        .supply_ok (supply_ok),
        .ad_o      (ad_o),
        .ad_oe     (ad_oe),
        .int_n_o   (int_n_o),
        .int_n_oe  (int_n_oe),
        .tick_out  (tick_out)
    );

    rtc_host_model host (
        .clk_sys (clk_sys),
        .ad_o    (ad_o),
        .ad_oe   (ad_oe),
        .bus_out (bus_in)
    );

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: pin got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(addr, d);
        check8(d, exp);
    endtask

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Ceiling: two preset updates of about 33k clk each plus bus traffic
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            fail_count++;
            $display("Error at %0t: timeout", $time);
            stop_test();
        end
    end

    initial begin
        int   i;
        logic seen;
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd_chk(ADDR_CTRL_A, 8'h00);
        rd_chk(ADDR_CTRL_B, 8'h00);
        rd_chk(ADDR_FLAGS, 8'h00);
        rd_chk(ADDR_VALID, 8'h80);
        host.wr(8'h0E, 8'hA5);
        host.wr(8'hFF, 8'h5A);
        rd_chk(8'h0E, 8'hA5);
        rd_chk(8'hFF, 8'h5A);
        // Refused accesses leave storage alone
        host.ext <= 1'b1;
        host.wr(8'h0E, 8'h00);
        host.ext <= 1'b0;
        rd_chk(8'h0E, 8'hA5);
        supply_ok <= 1'b0;
        host.wr(8'hFF, 8'h00);
        supply_ok <= 1'b1;
        rd_chk(8'hFF, 8'h5A);
        host.wr(ADDR_CTRL_A, 8'h80);
        rd_chk(ADDR_CTRL_A, 8'h00);
        host.wr(ADDR_FLAGS, 8'hF0);
        rd_chk(ADDR_FLAGS, 8'h00);
        seen = 1'b0;
        repeat (16) begin
            @(posedge clk_sys);
            seen = seen | (tick_out === 1'b1);
        end
        check1(seen, 1'b0);
        host.wr(ADDR_CTRL_B, 8'h96);
        rd_chk(ADDR_CTRL_B, 8'h86);
        for (i = 0; i < 10; i++) begin
            host.wr(8'(i), prog[i]);
        end
        rd_chk(8'h04, 8'h17);
        host.wr(ADDR_CTRL_B, 8'h36);
        host.wr(ADDR_CTRL_A, 8'h23);
        seen = 1'b0;
        repeat (16) begin
            @(posedge clk_sys);
            seen = seen | (tick_out === 1'b1);
        end
        check1(seen, 1'b1);
        repeat (40) @(posedge clk_sys);
        check1(int_pin, 1'b1);
        rd_chk(ADDR_FLAGS, 8'h40);
        rd_chk(ADDR_CTRL_A, 8'h23);
        // Poll for the pending bit ahead of the first update
        seen = 1'b0;
        for (i = 0; i < 3000 && !seen; i++) begin
            host.rd(ADDR_CTRL_A, rdata);
            seen = (rdata[7] === 1'b1);
        end
        check1(seen, 1'b1);
        rd_chk(8'h00, 8'h3B);
        for (i = 0; i < 400 && int_pin !== 1'b0; i++) begin
            @(posedge clk_sys);
        end
        check1(int_pin, 1'b0);
        rd_chk(ADDR_CTRL_A, 8'h23);
        for (i = 0; i < 10; i++) begin
            rd_chk(8'(i), expv[i]);
        end
        rd_chk(ADDR_FLAGS, 8'hF0);
        repeat (2) @(posedge clk_sys);
        check1(int_pin, 1'b1);
        rd_chk(ADDR_FLAGS, 8'h40);
        // 12-hour BCD year-end rollover; a restart keeps the next update near
        host.wr(ADDR_CTRL_B, 8'h80);
        host.wr(8'h00, 8'h59);
        host.wr(8'h02, 8'h59);
        host.wr(8'h04, 8'h91);
        host.wr(8'h06, 8'h03);
        host.wr(8'h07, 8'h31);
        host.wr(8'h08, 8'h12);
        host.wr(8'h09, 8'h99);
        host.wr(ADDR_CTRL_A, 8'h03);
        host.rd(ADDR_FLAGS, rdata);
        host.wr(ADDR_CTRL_B, 8'h00);
        host.wr(ADDR_CTRL_A, 8'h23);
        repeat (32840) @(posedge clk_sys);
        rd_chk(8'h00, 8'h00);
        rd_chk(8'h02, 8'h00);
        rd_chk(8'h04, 8'h12);
        rd_chk(8'h06, 8'h04);
        rd_chk(8'h07, 8'h01);
        rd_chk(8'h08, 8'h01);
        rd_chk(8'h09, 8'h00);
        check1(int_pin, 1'b1);
        rd_chk(ADDR_FLAGS, 8'h70);
        stop_test();
    end
endmodule
